// file: logic/plcmd_pkg.sv
// constants shared by the command handler and its helpers
// assumes byte-wide command and reply streams and a 32-bit register bus
package plcmd_pkg;
    // framing bytes and command codes
    localparam logic [7:0] SOH_BYTE = 8'h01;
    localparam logic [7:0] ETX_BYTE = 8'h03;
    localparam logic [7:0] DATA_PACKET_START = 8'h81;
    localparam logic [7:0] CMD_PL_TRANSIT = 8'h72;
    localparam logic [7:0] CMD_PL_QUERY = 8'h73;
    localparam logic [7:0] CMD_AL_QUERY = 8'h75;
    localparam logic [7:0] REPLY_ERR_FLAG = 8'h80;
    // lengths
    localparam logic [7:0] LEN_TRANSIT = 8'h03;
    localparam logic [7:0] LEN_QUERY = 8'h01;
    localparam logic [7:0] LEN_SHORT_REPLY = 8'h02;
    localparam logic [7:0] LEN_STATUS_REPLY = 8'h0a;
    localparam logic [7:0] BODY_MAX = 8'h04;
    // level codes, shared by protection and authentication levels
    localparam logic [7:0] LEVEL2 = 8'h02;
    localparam logic [7:0] LEVEL1 = 8'h03;
    localparam logic [7:0] LEVEL0 = 8'h04;
    localparam logic [31:0] UNUSED_WORD = 32'hffffffff;
    // status codes; only ok has a fixed value, the rest are local choices
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_PACKET = 8'hc1;
    localparam logic [7:0] STS_CHECKSUM = 8'hc2;
    localparam logic [7:0] STS_ACCEPT = 8'hc3;
    localparam logic [7:0] STS_PARAM = 8'hc5;
    localparam logic [7:0] STS_PROTECT = 8'hda;
    localparam logic [7:0] STS_FLASH = 8'he1;
    localparam logic [7:0] STS_HARDWARE = 8'he2;
    // register map, byte offsets
    localparam logic [3:0] REG_LEVEL_STATUS = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h4;
    localparam logic [3:0] REG_LAST_REPLY = 4'h8;
    // field positions and reset values
    localparam int ST_HUNG_BIT = 8;
    localparam int ST_ENC_BIT = 9;
    localparam int ST_BUSY_BIT = 10;
    localparam int CTRL_LIFECYCLE_BIT = 8;
    localparam logic [7:0] CTRL_AL_RESET = 8'h04;
    localparam logic CTRL_LIFECYCLE_RESET = 1'b1;
endpackage

// file: logic/level_move_table.sv
// fixed lookup of permitted protection-level moves
// assumes level codes as in the package; purely combinational
`timescale 1ns/1ns
`default_nettype none
module level_move_table
    import plcmd_pkg::*;
(
    input wire logic [7:0] src_code,
    input wire logic [7:0] dst_code,
    input wire logic [7:0] auth_code,
    output logic reachable,
    output logic allowed
);
    // only levels 0 and 1 may leave; level 2 is final
    always_comb begin
        reachable = 1'b0;
        if ((src_code == LEVEL0 && (dst_code == LEVEL1 || dst_code == LEVEL2)) ||
            (src_code == LEVEL1 && (dst_code == LEVEL0 || dst_code == LEVEL2))) begin
            reachable = 1'b1;
        end
    end

    // any reachable move not listed here is a protection error
    always_comb begin
        allowed = 1'b0;
        if (src_code == LEVEL0 && dst_code == LEVEL1 &&
            (auth_code == LEVEL2 || auth_code == LEVEL1)) begin
            allowed = 1'b1;
        end else if (src_code == LEVEL1 && dst_code == LEVEL0 && auth_code == LEVEL1) begin
            allowed = 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: logic/reply_sender.sv
// serialises one data packet: short level reply or ten-byte status reply
// assumes the sink takes a byte on tx_valid and tx_ready both high
`timescale 1ns/1ns
`default_nettype none
module reply_sender
    import plcmd_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic start,
    input wire logic short_form,
    input wire logic [7:0] reply_code,
    input wire logic [7:0] status_code,
    input wire logic [31:0] status_detail_word,
    input wire logic [7:0] level_data,
    output logic busy,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    logic [3:0] idx_q;
    logic [7:0] sum_q;
    logic short_q;
    logic [7:0] code_q, sts_q, lvl_q;
    logic [31:0] det_q;
    logic [7:0] len;
    logic [7:0] next_byte;
    logic [3:0] nidx;
    logic take;

    assign len = short_q ? LEN_SHORT_REPLY : LEN_STATUS_REPLY;
    assign take = tx_valid && tx_ready;
    assign nidx = idx_q + 4'h1;
    assign busy = tx_valid;

    // byte at position nidx; the location field is always the unused code
    always_comb begin
        next_byte = UNUSED_WORD[7:0];
        if (nidx == 4'h1) begin
            next_byte = 8'h00;
        end else if (nidx == 4'h2) begin
            next_byte = len;
        end else if (nidx == 4'h3) begin
            next_byte = code_q;
        end else if ({4'h0, nidx} == len + 8'h03) begin
            next_byte = 8'h00 - (sum_q + tx_data);
        end else if ({4'h0, nidx} == len + 8'h04) begin
            next_byte = ETX_BYTE;
        end else if (short_q) begin
            next_byte = lvl_q;
        end else if (nidx == 4'h4) begin
            next_byte = sts_q;
        end else if (nidx <= 4'h8) begin
            next_byte = det_q[8'd31 - 8'd8 * (8'(nidx) - 8'd5) -: 8];
        end
    end

    // fields are frozen for the whole packet
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            short_q <= 1'b0;
            code_q <= 8'h00;
            sts_q <= 8'h00;
            lvl_q <= 8'h00;
            det_q <= 32'h00000000;
        end else if (start && !tx_valid) begin
            short_q <= short_form;
            code_q <= reply_code;
            sts_q <= status_code;
            lvl_q <= level_data;
            det_q <= status_detail_word;
        end
    end

    // byte sequencer with running sum over length, code and payload
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            idx_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (start && !tx_valid) begin
            tx_valid <= 1'b1;
            tx_data <= DATA_PACKET_START;
            idx_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (take) begin
            if ({4'h0, idx_q} == len + 8'h04) begin
                tx_valid <= 1'b0;
            end else begin
                tx_data <= next_byte;
                idx_q <= nidx;
                if (idx_q != 4'h0) begin
                    sum_q <= sum_q + tx_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/protection_level_cmd_handler.sv
// boot-mode handler for protection and authentication level commands
// assumes byte streams, a flash sequencer port and an avalon master
// Contract
// - report only highest priority error
// - unused code in detail and location fields
// - flash error carries flash status detail
// - lifecycle forbids transit: acceptance error
// - pending encrypted write refuses every command
// - source code mismatch: parameter error
// - unreachable destination: parameter error
// - insufficient authentication: protection error
// - invalid read-back level: hardware error
// - wait for header byte, drop others
// - missing trailer: packet error
// - wrong checksum: checksum error
// - wrong length bytes: packet error
// - errors skip execution, back to waiting
// - level query replies code and level
// - level codes 02h, 03h, 04h
// - failed query: status reply form
// - after flash error keep serving
// - after hardware error stop responding
`timescale 1ns/1ns
`default_nettype none
module protection_level_cmd_handler
    import plcmd_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic flash_req,
    output logic [7:0] flash_code,
    input wire logic flash_done,
    input wire logic flash_err,
    input wire logic [31:0] flash_status,
    input wire logic [7:0] current_protect_code,
    input wire logic enc_write_done,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import plcmd_pkg::*;

    typedef enum logic [3:0] {
        S_WAIT_SOH = 4'h0,
        S_LEN_H = 4'h1,
        S_LEN_L = 4'h3,
        S_BODY = 4'h2,
        S_SUM = 4'h6,
        S_ETX = 4'h7,
        S_CHECK = 4'h5,
        S_FLASH = 4'h4,
        S_REPLY = 4'hc,
        S_HUNG = 4'hd
    } state_t;

    state_t state_q;
    logic [7:0] lnh_q, len_q, sum_q;
    logic [1:0] cnt_q;
    logic [7:0] body_q [0:3];
    logic fmt_bad_q, etx_bad_q;
    logic hang_q, enc_pending_q, start_q;
    logic [7:0] auth_level_q;
    logic lifecycle_ok_q;
    logic rep_short_q;
    logic [7:0] rep_code_q, rep_status_q, rep_level_q;
    logic [31:0] rep_detail_q;
    logic ack_q;
    logic accept, busy, reachable, allowed;
    logic [7:0] cmd, src, dst;
    logic chk_err, chk_go;
    logic [7:0] chk_status;
    logic bad_level, len_bad;

    assign cmd = body_q[0];
    assign src = body_q[1];
    assign dst = body_q[2];
    // hung state swallows bytes silently
    assign rx_ready = !(state_q inside {S_CHECK, S_FLASH, S_REPLY});
    assign accept = rx_valid && rx_ready;
    assign flash_req = (state_q == S_FLASH);
    assign flash_code = dst;
    assign bad_level = current_protect_code != LEVEL0 && current_protect_code != LEVEL1 &&
                       current_protect_code != LEVEL2;
    assign len_bad = lnh_q != 8'h00 || rx_data == 8'h00 || rx_data > BODY_MAX;

    level_move_table u_table (
        .src_code(current_protect_code),
        .dst_code(dst),
        .auth_code(auth_level_q),
        .reachable(reachable),
        .allowed(allowed)
    );

    reply_sender u_sender (
        .mclk(mclk),
        .rstn(rstn),
        .start(start_q),
        .short_form(rep_short_q),
        .reply_code(rep_code_q),
        .status_code(rep_status_q),
        .status_detail_word(rep_detail_q),
        .level_data(rep_level_q),
        .busy(busy),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready)
    );

    // ranked checks; the first hit wins
    always_comb begin
        chk_err = 1'b1;
        chk_go = 1'b0;
        chk_status = STS_OK;
        if (etx_bad_q) begin
            chk_status = STS_PACKET;
        end else if (sum_q != 8'h00) begin
            chk_status = STS_CHECKSUM;
        end else if (fmt_bad_q) begin
            chk_status = STS_PACKET;
        end else if (!((cmd == CMD_PL_TRANSIT && len_q == LEN_TRANSIT) ||
                       ((cmd == CMD_PL_QUERY || cmd == CMD_AL_QUERY) &&
                        len_q == LEN_QUERY))) begin
            chk_status = STS_PACKET;
        end else if (cmd == CMD_PL_TRANSIT && !lifecycle_ok_q) begin
            chk_status = STS_ACCEPT;
        end else if (enc_pending_q) begin
            chk_status = STS_ACCEPT;
        end else if (cmd != CMD_PL_TRANSIT) begin
            chk_err = 1'b0;
        end else if (src != current_protect_code) begin
            chk_status = STS_PARAM;
        end else if (!reachable) begin
            chk_status = STS_PARAM;
        end else if (!allowed) begin
            chk_status = STS_PROTECT;
        end else begin
            chk_err = 1'b0;
            chk_go = 1'b1;
        end
    end

    // packet framing and command sequencing
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= S_WAIT_SOH;
            lnh_q <= 8'h00;
            len_q <= 8'h00;
            sum_q <= 8'h00;
            cnt_q <= 2'b00;
            fmt_bad_q <= 1'b0;
            etx_bad_q <= 1'b0;
            hang_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                S_WAIT_SOH: begin
                    if (accept && rx_data == SOH_BYTE) begin
                        state_q <= S_LEN_H;
                    end
                end
                S_LEN_H: begin
                    if (accept) begin
                        lnh_q <= rx_data;
                        sum_q <= rx_data;
                        state_q <= S_LEN_L;
                    end
                end
                S_LEN_L: begin
                    if (accept) begin
                        len_q <= rx_data;
                        sum_q <= sum_q + rx_data;
                        cnt_q <= 2'b00;
                        // a bad length cannot size the body, so go straight to the sum
                        fmt_bad_q <= len_bad;
                        state_q <= len_bad ? S_SUM : S_BODY;
                    end
                end
                S_BODY: begin
                    if (accept) begin
                        sum_q <= sum_q + rx_data;
                        cnt_q <= cnt_q + 2'b01;
                        if ({6'h00, cnt_q} == len_q - 8'h01) begin
                            state_q <= S_SUM;
                        end
                    end
                end
                S_SUM: begin
                    if (accept) begin
                        sum_q <= sum_q + rx_data;
                        state_q <= S_ETX;
                    end
                end
                S_ETX: begin
                    if (accept) begin
                        etx_bad_q <= rx_data != ETX_BYTE;
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (chk_go) begin
                        state_q <= S_FLASH;
                    end else begin
                        start_q <= 1'b1;
                        state_q <= S_REPLY;
                    end
                end
                S_FLASH: begin
                    if (flash_done) begin
                        // invalid read-back only matters once the flash reports clean
                        hang_q <= !flash_err && bad_level;
                        start_q <= 1'b1;
                        state_q <= S_REPLY;
                    end
                end
                S_REPLY: begin
                    if (!start_q && !busy) begin
                        state_q <= hang_q ? S_HUNG : S_WAIT_SOH;
                    end
                end
                S_HUNG: begin
                    state_q <= S_HUNG;
                end
                default: begin
                    state_q <= S_WAIT_SOH;
                end
            endcase
        end
    end

    // a skipped body leaves command 00h, read as unknown
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                body_q[i] <= 8'h00;
            end
        end else if (state_q == S_WAIT_SOH && accept) begin
            body_q[0] <= 8'h00;
        end else if (state_q == S_BODY && accept) begin
            body_q[cnt_q] <= rx_data;
        end
    end

    // reply fields for the sender
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rep_short_q <= 1'b0;
            rep_code_q <= 8'h00;
            rep_status_q <= STS_OK;
            rep_level_q <= 8'h00;
            rep_detail_q <= UNUSED_WORD;
        end else if (state_q == S_CHECK && !chk_go) begin
            rep_short_q <= !chk_err && cmd != CMD_PL_TRANSIT;
            rep_code_q <= chk_err ? (cmd | REPLY_ERR_FLAG) : cmd;
            rep_status_q <= chk_status;
            rep_detail_q <= UNUSED_WORD;
            rep_level_q <= (cmd == CMD_AL_QUERY) ? auth_level_q :
                           current_protect_code;
        end else if (state_q == S_FLASH && flash_done) begin
            rep_short_q <= 1'b0;
            if (flash_err) begin
                rep_code_q <= cmd | REPLY_ERR_FLAG;
                rep_status_q <= STS_FLASH;
                rep_detail_q <= flash_status;
            end else if (bad_level) begin
                rep_code_q <= cmd | REPLY_ERR_FLAG;
                rep_status_q <= STS_HARDWARE;
                rep_detail_q <= UNUSED_WORD;
            end else begin
                rep_code_q <= cmd;
                rep_status_q <= STS_OK;
                rep_detail_q <= UNUSED_WORD;
            end
        end
    end

    // encrypted-write marker only a device reset clears
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            enc_pending_q <= 1'b0;
        end else if (enc_write_done) begin
            enc_pending_q <= 1'b1;
        end
    end

    // avalon slave: one wait cycle, then the answer
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // control register writes on the accepting edge only
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            auth_level_q <= CTRL_AL_RESET;
            lifecycle_ok_q <= CTRL_LIFECYCLE_RESET;
        end else if (avs_write && ack_q && avs_address == REG_CONTROL) begin
            if (avs_byteenable[0]) begin
                auth_level_q <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                lifecycle_ok_q <= avs_writedata[CTRL_LIFECYCLE_BIT];
            end
        end
    end

    // read data captured in the wait cycle; unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= 32'h00000000;
            unique case (avs_address)
                REG_LEVEL_STATUS: begin
                    avs_readdata[7:0] <= current_protect_code;
                    avs_readdata[ST_HUNG_BIT] <= hang_q;
                    avs_readdata[ST_ENC_BIT] <= enc_pending_q;
                    avs_readdata[ST_BUSY_BIT] <= state_q != S_WAIT_SOH;
                end
                REG_CONTROL: begin
                    avs_readdata[7:0] <= auth_level_q;
                    avs_readdata[CTRL_LIFECYCLE_BIT] <= lifecycle_ok_q;
                end
                REG_LAST_REPLY: begin
                    avs_readdata[15:0] <= {rep_code_q, rep_status_q};
                end
                default: begin
                    avs_readdata <= 32'h00000000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/flash_model.sv
// flash sequencer and level store behind the flash port
// assumes one request at a time, ended by a single done pulse
`timescale 1ns/1ns
`default_nettype none
module flash_model(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic flash_req,
    input wire logic [7:0] flash_code,
    input wire logic slow,
    input wire logic fail,
    input wire logic bad,
    output logic flash_done,
    output logic flash_err,
    output logic [31:0] flash_status,
    output logic [7:0] current_protect_code
);
    logic [3:0] cnt_q = 4'h0;
    initial {flash_done, flash_err, flash_status, current_protect_code} = '0;
    // done after 2 or 10 cycles; status toggles off done
    always @(posedge mclk) begin
        flash_done <= 1'b0;
        flash_err <= ~flash_err;
        flash_status <= ~flash_status;
        cnt_q <= (flash_req && !flash_done) ? cnt_q + 4'h1 : 4'h0;
        if (!rstn)
            current_protect_code <= 8'h04;
        if (flash_req && !flash_done && cnt_q == (slow ? 4'h9 : 4'h1)) begin
            flash_done <= 1'b1;
            flash_err <= fail;
            flash_status <= 32'h0000_5a10;
            if (!fail)
                current_protect_code <= bad ? 8'h07 : flash_code;
        end
    end
endmodule
`default_nettype wire

// file: tb/plcmd_asserts.sv
// port-level checks on the command handler
// assumes one clock and synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module plcmd_asserts
    import plcmd_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic flash_req,
    input wire logic [7:0] flash_code,
    input wire logic flash_done,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence bus_start;
        $rose(avs_read || avs_write);
    endsequence
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    bus_wait_a: assert property (bus_start |-> one_wait) else $error("bus wait not one cycle");
    idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("wait while idle");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped");
    reply_start_a: assert property ($rose(tx_valid) |-> tx_data == DATA_PACKET_START)
        else $error("reply lacks start byte");
    rx_block_a: assert property (tx_valid |-> !rx_ready)
        else $error("receiving while replying");
    flash_hold_a: assert property (flash_req && !flash_done |=> flash_req && $stable(flash_code))
        else $error("flash request not held");
    flash_excl_a: assert property (flash_req |-> !rx_ready && !tx_valid)
        else $error("flash request overlaps link");
    flash_reply_a: assert property (flash_req && flash_done |-> ##[1:8] tx_valid)
        else $error("no reply after flash");
endmodule
bind protection_level_cmd_handler plcmd_asserts u_chk(.mclk, .rstn, .rx_ready, .tx_valid,
    .tx_data, .tx_ready, .flash_req, .flash_code, .flash_done, .avs_read, .avs_write,
    .avs_waitrequest);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the command handler
// assumes the flash model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb;
    import plcmd_pkg::*;
    logic mclk = 0, rstn = 0, rx_valid = 0, tx_ready = 1, avs_read = 0, avs_write = 0;
    logic slow = 0, fail = 0, bad = 0, stall = 0, enc_write_done = 0;
    logic [7:0] rx_data = 8'h0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0, rd;
    logic rx_ready, tx_valid, flash_req, flash_done, flash_err, avs_waitrequest;
    logic [7:0] tx_data, flash_code, current_protect_code;
    logic [31:0] flash_status, avs_readdata;
    logic [7:0] ex[$];
    int n_fail = 0, tests_run = 0;
    always #10 mclk = ~mclk;
    protection_level_cmd_handler u_dut(.mclk, .rstn, .rx_valid, .rx_data, .rx_ready,
        .tx_valid, .tx_data, .tx_ready, .flash_req, .flash_code, .flash_done, .flash_err,
        .flash_status, .current_protect_code, .enc_write_done, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    flash_model u_flash(.mclk, .rstn, .flash_req, .flash_code, .slow, .fail, .bad,
        .flash_done, .flash_err, .flash_status, .current_protect_code);
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        complete_run;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waitrequest judged mid-cycle, clear of the edge race
    task automatic bus(input logic wr, input logic [3:0] a, be, input logic [31:0] d);
        int i;
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(negedge mclk);
            if (!avs_waitrequest) break;
        end
        if (i == 20) tmo;
        @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    // valid stays up between bytes
    task automatic sendb(input logic [7:0] b);
        int i;
        rx_valid <= 1'b1;
        rx_data <= b;
        for (i = 0; i < 60; i++) begin
            @(negedge mclk);
            if (rx_ready) break;
        end
        if (i == 60) tmo;
        @(posedge mclk);
    endtask
    // dsum skews the check byte
    task automatic pkt(input logic [7:0] q[$], input logic [7:0] etx, dsum);
        logic [7:0] s = dsum;
        foreach (q[k]) s -= q[k];
        sendb(SOH_BYTE);
        foreach (q[k]) sendb(q[k]);
        sendb(s);
        sendb(etx);
        rx_valid <= 1'b0;
    endtask
    // adds check and trailer, takes reply
    task automatic reply;
        int i;
        logic [7:0] s = 8'h0;
        for (int k = 1; k < ex.size(); k++) s -= ex[k];
        ex.push_back(s);
        ex.push_back(ETX_BYTE);
        foreach (ex[k]) begin
            for (i = 0; i < 100; i++) begin
                @(negedge mclk);
                if (tx_valid && tx_ready) break;
                @(posedge mclk);
                tx_ready <= stall ? !tx_ready : 1'b1;
            end
            if (i == 100) tmo;
            chk(tx_data, ex[k]);
            @(posedge mclk);
        end
    endtask
    task automatic stat(input logic [7:0] c, s, input logic [31:0] d);
        ex = {DATA_PACKET_START, 8'h00, LEN_STATUS_REPLY, c, s, d[31:24], d[23:16], d[15:8],
            d[7:0], 8'hff, 8'hff, 8'hff, 8'hff};
        reply;
    endtask
    task automatic query(input logic [7:0] c, v);
        pkt('{8'h00, LEN_QUERY, c}, ETX_BYTE, 8'h00);
        ex = {DATA_PACKET_START, 8'h00, LEN_SHORT_REPLY, c, v};
        reply;
    endtask
    task automatic move(input logic [7:0] sc, dc, s, input logic [31:0] d);
        pkt('{8'h00, LEN_TRANSIT, CMD_PL_TRANSIT, sc, dc}, ETX_BYTE, 8'h00);
        stat(s == STS_OK ? CMD_PL_TRANSIT : 8'hf2, s, d);
    endtask
    task automatic rst;
        rstn <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
    endtask
    task automatic t_regs;
        bus(0, REG_CONTROL, 4'hf, 0);
        chk(rd, 32'h0000_0104);
        bus(0, 4'hc, 4'hf, 0);
        chk(rd, 32'h0);
        bus(0, REG_LEVEL_STATUS, 4'hf, 0);
        chk(rd, 32'h0000_0004);
    endtask
    task automatic t_frame;
        stall = 1'b1;
        sendb(8'h55);
        query(CMD_PL_QUERY, LEVEL0);
        query(CMD_AL_QUERY, LEVEL0);
        stall = 1'b0;
        pkt('{8'h00, LEN_QUERY, CMD_PL_QUERY}, 8'h00, 8'h01);
        stat(8'hf3, STS_PACKET, UNUSED_WORD);
        pkt('{8'h00, LEN_QUERY, CMD_PL_QUERY}, ETX_BYTE, 8'h01);
        stat(8'hf3, STS_CHECKSUM, UNUSED_WORD);
        pkt('{8'h00, 8'h02, CMD_PL_QUERY, 8'h00}, ETX_BYTE, 8'h00);
        stat(8'hf3, STS_PACKET, UNUSED_WORD);
    endtask
    task automatic t_moves;
        move(LEVEL0, LEVEL1, STS_PROTECT, UNUSED_WORD);
        bus(1, REG_CONTROL, 4'h1, {24'h0, LEVEL1});
        bus(1, REG_CONTROL, 4'h2, 32'h0);
        move(LEVEL0, LEVEL1, STS_ACCEPT, UNUSED_WORD);
        bus(1, REG_CONTROL, 4'h2, 32'h0000_0100);
        move(LEVEL1, LEVEL0, STS_PARAM, UNUSED_WORD);
        slow = 1'b1;
        move(LEVEL0, LEVEL1, STS_OK, UNUSED_WORD);
        slow = 1'b0;
        query(CMD_PL_QUERY, LEVEL1);
        move(LEVEL1, LEVEL1, STS_PARAM, UNUSED_WORD);
        move(LEVEL1, LEVEL2, STS_PROTECT, UNUSED_WORD);
        fail = 1'b1;
        move(LEVEL1, LEVEL0, STS_FLASH, 32'h0000_5a10);
        fail = 1'b0;
        query(CMD_PL_QUERY, LEVEL1);
    endtask
    task automatic t_hang;
        logic hit = 1'b0;
        bad = 1'b1;
        move(LEVEL1, LEVEL0, STS_HARDWARE, UNUSED_WORD);
        bad = 1'b0;
        pkt('{8'h00, LEN_QUERY, CMD_PL_QUERY}, ETX_BYTE, 8'h00);
        repeat (60) @(posedge mclk) hit |= tx_valid;
        chk(hit, 1'b0);
        bus(0, REG_LEVEL_STATUS, 4'hf, 0);
        chk(rd[ST_HUNG_BIT], 1'b1);
    endtask
    task automatic t_enc;
        enc_write_done <= 1'b1;
        @(posedge mclk);
        enc_write_done <= 1'b0;
        pkt('{8'h00, LEN_QUERY, CMD_AL_QUERY}, ETX_BYTE, 8'h00);
        stat(8'hf5, STS_ACCEPT, UNUSED_WORD);
        move(LEVEL0, LEVEL1, STS_ACCEPT, UNUSED_WORD);
        bus(0, REG_LEVEL_STATUS, 4'hf, 0);
        chk(rd[ST_ENC_BIT], 1'b1);
    endtask
    initial begin
        rst;
        t_regs;
        t_frame;
        t_moves;
        t_hang;
        rst;
        t_enc;
        complete_run;
    end
endmodule
`default_nettype wire
